// [hdl/ecb_pkg.sv]
package ecb_pkg;
  // bus cycle phases
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_strobe = 4'h2,
    st_wait = 4'h4,
    st_done = 4'h8
  } ecb_state_t;

  // chip select group, active low; app and disk follow the sensed polarity
  typedef struct packed {
    logic program_memory_select_n;
    logic external_ram_select_n;
    logic application_space_select_n;
    logic disk_controller_select_n;
  } ecb_selects_t;

  // captured straps
  typedef struct packed {
    logic [5:0] option_straps;
    logic [1:0] host_link_number_straps;
  } chip_configuration_register_t;

  // one core request
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ecb_req_t;

  // whole module state
  typedef struct packed {
    ecb_state_t state;
    logic [2:0] wait_cnt;
    logic last_prog;
    logic cur_prog;
    logic cur_write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic prog_ack;
    logic data_ack;
    ecb_selects_t sel;
    logic rd_n;
    logic wr_n;
    logic dout_en;
    logic byte_select_output;
    logic rst_seen;
    logic polarity_sense;
    logic [1:0] sel_pol;
    chip_configuration_register_t cfg;
    logic ph2;
    logic internal_program_read_qualifier_n;
    logic gp_oe;
  } ecb_state_all_t;
endpackage

// [hdl/ecb_regs.svh]
`ifndef ECB_REGS_SVH
`define ECB_REGS_SVH
// data space region bounds
`define ECB_BANK_LO 16'h2000
`define ECB_BANK_HI 16'h9fff
`define ECB_PROM_LO 16'ha000
`define ECB_PROM_HI 16'hbfff
`define ECB_APP_LO 16'hc000
`define ECB_APP_HI 16'hcfff
`define ECB_DISK_LO 16'hd000
`define ECB_DISK_HI 16'hdfff
// strap field positions on the low data pins
`define ECB_STRAP_ID_LSB 0
`define ECB_STRAP_OPT_LSB 2
// sensed select polarity field, app then disk
`define ECB_POL_LSB 8
// bank index field of an address, first external bank code
`define ECB_BANK_MSB 15
`define ECB_BANK_LSB 13
`define ECB_BANK_FIRST 3'h1
// wait states added for application and disk controller space
`define ECB_DISK_WAIT 3'h3
`define ECB_RESET_WAIT 3'h0
`endif

// [hdl/external_common_bus_interface.sv]
`timescale 1ns/1ns
`include "ecb_regs.svh"
// Behaviour
// - capture low eight data pins at reset release as straps, readable
// - in 8-bit bus mode data pin 15 outputs byte select on writes
// - drive active-low program memory select for program memory accesses
// - application select enabled drives general pin eleven as select, low unless polarity is sensed
// - test pin tied to reset senses select polarity, else default
// - phase-two clock driven only in internal trace mode
// - internal program read qualifier driven low in trace mode fetches
// - common bus serves both program and data requests, interleaved
// - program requests are read-only instruction fetches over 64K
// - data requests read or write over 64K data space
// - decode places regions into program and data spaces
// - bank 2000-9fff selects ram if enabled, else rom
// - application space to cfff selects app when app select is enabled and adds disk wait states
// - d000-dfff data access asserts disk controller select
module external_common_bus_interface
  import ecb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic byte_mode_i,
  input wire logic app_select_enable_i,
  input wire logic prom_program_mode_i,
  input wire logic [2:0] ram_banks_i,
  input wire logic trace_enable_i,
  input wire logic test_n_i,
  // program bus, read only
  input wire logic prog_req_i,
  input wire logic [15:0] prog_addr_i,
  output logic prog_ack_o,
  // data bus
  input wire ecb_req_t data_req_i,
  output logic data_ack_o,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // straps
  output chip_configuration_register_t chip_configuration_register_o,
  // external pins
  output logic [15:0] common_address_bus_o,
  input wire logic [15:0] common_data_bus_i,
  output logic [15:0] common_data_bus_o,
  output logic common_data_bus_oe_o,
  output logic byte_select_output_o,
  output logic bus_read_strobe_n_o,
  output logic bus_write_strobe_n_o,
  output ecb_selects_t selects_o,
  output logic general_pin_eleven_o,
  output logic general_pin_eleven_oe_o,
  output logic phase_two_clock_out_o,
  output logic internal_program_read_qualifier_n_o
);

  ecb_state_all_t s_q, s_d;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // decode one access into selects (active high here)
  function automatic logic [3:0] decode(input logic prog, input logic [15:0] a, input logic [2:0] banks,
                                        input logic prom_mode);
    logic [2:0] bank;
    logic [3:0] r;
    // 2000h is bank 0, 8000h is bank 3
    bank = a[`ECB_BANK_MSB:`ECB_BANK_LSB] - `ECB_BANK_FIRST;
    r = 4'h0;
    if (prog) begin
      r[3] = 1'b1;
    end else if (in_range(a, `ECB_BANK_LO, `ECB_BANK_HI)) begin
      if (bank < banks) r[2] = 1'b1;
      else r[3] = 1'b1;
    end else if (in_range(a, `ECB_PROM_LO, `ECB_PROM_HI)) begin
      r[3] = prom_mode;
    end else if (in_range(a, `ECB_APP_LO, `ECB_APP_HI)) begin
      r[1] = 1'b1;
    end else if (in_range(a, `ECB_DISK_LO, `ECB_DISK_HI)) begin
      r[0] = 1'b1;
    end
    decode = r;
  endfunction

  logic [3:0] dec;
  logic take_prog;
  logic take_data;

  // arbitration, decode and bus sequencing
  always_comb begin
    s_d = s_q;
    s_d.prog_ack = 1'b0;
    s_d.data_ack = 1'b0;
    s_d.rvalid = 1'b0;
    dec = 4'h0;
    // alternate between the two sources when both ask
    take_prog = prog_req_i && (!data_req_i.valid || !s_q.last_prog);
    take_data = data_req_i.valid && !take_prog;
    // straps taken at the first clock after reset release
    s_d.rst_seen = 1'b1;
    if (!s_q.rst_seen) begin
      s_d.cfg.host_link_number_straps = common_data_bus_i[`ECB_STRAP_ID_LSB +: 2];
      s_d.cfg.option_straps = common_data_bus_i[`ECB_STRAP_OPT_LSB +: 6];
      // test pin low through reset means it follows reset: sense polarity
      s_d.sel_pol = s_q.polarity_sense ? common_data_bus_i[`ECB_POL_LSB +: 2] : 2'h0;
      s_d.sel.application_space_select_n = !s_d.sel_pol[1];
      s_d.sel.disk_controller_select_n = !s_d.sel_pol[0];
    end
    // trace qualifiers
    s_d.ph2 = trace_enable_i ? !s_q.ph2 : 1'b0;
    // pin eleven driven only while app select is enabled
    s_d.gp_oe = app_select_enable_i;
    case (s_q.state)
      st_idle: begin
        if (take_prog || take_data) begin
          s_d.cur_prog = take_prog;
          s_d.last_prog = take_prog;
          s_d.cur_write = take_data && data_req_i.write;
          s_d.addr = take_prog ? prog_addr_i : data_req_i.addr;
          s_d.wdata = data_req_i.wdata;
          dec = decode(take_prog, s_d.addr, ram_banks_i, prom_program_mode_i);
          s_d.sel.program_memory_select_n = !dec[3];
          s_d.sel.external_ram_select_n = !dec[2];
          s_d.sel.application_space_select_n = !(dec[1] && app_select_enable_i) ^ s_d.sel_pol[1];
          s_d.sel.disk_controller_select_n = !dec[0] ^ s_d.sel_pol[0];
          s_d.wait_cnt = (dec[1] || dec[0]) ? `ECB_DISK_WAIT : `ECB_RESET_WAIT;
          s_d.byte_select_output = byte_mode_i && s_d.addr[0];
          if (byte_mode_i) s_d.wdata[15] = s_d.byte_select_output;
          s_d.dout_en = s_d.cur_write;
          s_d.internal_program_read_qualifier_n = !(trace_enable_i && take_prog);
          s_d.state = st_strobe;
        end
      end
      st_strobe: begin
        // exactly one strobe, address held
        s_d.rd_n = s_q.cur_write;
        s_d.wr_n = !s_q.cur_write;
        s_d.state = st_wait;
      end
      st_wait: begin
        if (s_q.wait_cnt != `ECB_RESET_WAIT) begin
          s_d.wait_cnt = s_q.wait_cnt - 3'h1;
        end else begin
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.rdata = common_data_bus_i;
          if (byte_mode_i) s_d.rdata = {8'h00, common_data_bus_i[7:0]};
          s_d.rvalid = !s_q.cur_write && !s_q.cur_prog;
          s_d.prog_ack = s_q.cur_prog;
          s_d.data_ack = !s_q.cur_prog;
          s_d.state = st_done;
        end
      end
      st_done: begin
        s_d.sel = '1;
        s_d.sel.application_space_select_n = !s_q.sel_pol[1];
        s_d.sel.disk_controller_select_n = !s_q.sel_pol[0];
        s_d.dout_en = 1'b0;
        s_d.internal_program_read_qualifier_n = 1'b1;
        s_d.state = st_idle;
      end
      default: s_d.state = st_idle;
    endcase
    if (!trace_enable_i) s_d.internal_program_read_qualifier_n = 1'b1;
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.state <= st_idle;
      s_q.sel <= '1;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.internal_program_read_qualifier_n <= 1'b1;
      s_q.polarity_sense <= !test_n_i;
    end else begin
      s_q <= s_d;
    end
  end

  // pin outputs, all from flip-flops
  assign prog_ack_o = s_q.prog_ack;
  assign data_ack_o = s_q.data_ack;
  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;
  assign chip_configuration_register_o = s_q.cfg;
  assign common_address_bus_o = s_q.addr;
  assign common_data_bus_o = s_q.wdata;
  assign common_data_bus_oe_o = s_q.dout_en;
  assign byte_select_output_o = s_q.byte_select_output;
  assign bus_read_strobe_n_o = s_q.rd_n;
  assign bus_write_strobe_n_o = s_q.wr_n;
  // selects already carry the sensed polarity
  assign selects_o = s_q.sel;
  assign general_pin_eleven_o = s_q.sel.application_space_select_n;
  assign general_pin_eleven_oe_o = s_q.gp_oe;
  assign phase_two_clock_out_o = s_q.ph2;
  assign internal_program_read_qualifier_n_o = s_q.internal_program_read_qualifier_n;

  // assertions
  property p_one_strobe;
    @(posedge clk_sys_i) disable iff (!rst_b_i) !(!s_q.rd_n && !s_q.wr_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes active");

  property p_addr_stable;
    @(posedge clk_sys_i) disable iff (!rst_b_i) (!s_q.rd_n && $past(!s_q.rd_n)) |-> $stable(s_q.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved under strobe");

  property p_ph2_off;
    @(posedge clk_sys_i) disable iff (!rst_b_i) !trace_enable_i |=> !s_q.ph2;
  endproperty
  a_ph2_off: assert property (p_ph2_off) else $error("phase two clock without trace");

  property p_internal_program_read_qualifier;
    @(posedge clk_sys_i) disable iff (!rst_b_i) !s_q.internal_program_read_qualifier_n |-> s_q.cur_prog;
  endproperty
  a_internal_program_read_qualifier: assert property (p_internal_program_read_qualifier) else $error("qualifier on data access");

  property p_prog_read;
    @(posedge clk_sys_i) disable iff (!rst_b_i) s_q.cur_prog && s_q.state == st_wait |-> s_q.wr_n;
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("program write");

  property p_disk_sel;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.state == st_idle && take_data && in_range(data_req_i.addr, `ECB_DISK_LO, `ECB_DISK_HI))
      |=> s_q.sel.disk_controller_select_n == s_q.sel_pol[0];
  endproperty
  a_disk_sel: assert property (p_disk_sel) else $error("disk select missing");

  property p_app_wait;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.state == st_idle && take_data && in_range(data_req_i.addr, `ECB_APP_LO, `ECB_APP_HI))
      |=> s_q.wait_cnt == `ECB_DISK_WAIT;
  endproperty
  a_app_wait: assert property (p_app_wait) else $error("app wait states missing");

  property p_prog_rom;
    @(posedge clk_sys_i) disable iff (!rst_b_i) (s_q.state == st_idle && take_prog)
      |=> !s_q.sel.program_memory_select_n ##1 !s_q.rd_n;
  endproperty
  a_prog_rom: assert property (p_prog_rom) else $error("program fetch without rom select");

  property p_alternate;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.state == st_idle && prog_req_i && data_req_i.valid && s_q.last_prog) |=> !s_q.cur_prog;
  endproperty
  a_alternate: assert property (p_alternate) else $error("no interleave");
endmodule

// [test/ext_mem_model.sv]
`timescale 1ns/1ns
module ext_mem_model
  import ecb_pkg::*;
#(
  parameter logic [15:0] STRAPS = 16'hffa5
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // device pins
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dev_data_i,
  input wire logic dev_oe_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire ecb_selects_t sel_i,
  // resolved data wire
  output logic [15:0] wire_o
);
  logic [15:0] mem_q [256];
  logic boot_q = 1'b0;
  // straps stay on the pins until the first edge after release
  always @(posedge clk_sys_i) begin
    boot_q <= rst_b_i;
  end
  // write taken while the strobe is low
  always @(negedge clk_sys_i) begin
    if (!wr_n_i && dev_oe_i && sel_i != 4'hf) begin
      mem_q[addr_i[7:0]] <= dev_data_i;
    end
  end
  // released lines float to the pull-up level
  assign wire_o = dev_oe_i ? dev_data_i : !boot_q ? STRAPS :
                  (!rd_n_i && sel_i != 4'hf) ? mem_q[addr_i[7:0]] : 16'hffff;
endmodule

// [test/external_common_bus_interface_tb_top.sv]
`timescale 1ns/1ns
module external_common_bus_interface_tb_top;
  import ecb_pkg::*;
  logic clk = 0, rst_b = 0, byte_m = 0, app_en = 0, trace = 0, prog_req = 0, test_n = 1, prom = 0;
  logic [2:0] banks = 3'h0;
  logic [15:0] prog_addr = 16'h0, rdata, caddr, dout, dwire, r;
  ecb_req_t dreq = '0;
  logic prog_ack, data_ack, rvalid, oe, byte_select_output, rd_n, wr_n, gp, gp_oe, ph2, qual_n;
  ecb_selects_t sel, sel_s;
  chip_configuration_register_t cfg;
  logic byte_select_output_s, gp_s, both_s = 0, wr_s = 0, qual_s = 0, ph2_p = 0;
  int err_total = 0, checked = 0, cyc = 0, tog = 0;

  external_common_bus_interface external_common_bus_interface_inst (
    .clk_sys_i(clk), .rst_b_i(rst_b), .byte_mode_i(byte_m), .app_select_enable_i(app_en),
    .prom_program_mode_i(prom), .ram_banks_i(banks), .trace_enable_i(trace),
    .test_n_i(test_n),
    .prog_req_i(prog_req), .prog_addr_i(prog_addr), .prog_ack_o(prog_ack),
    .data_req_i(dreq), .data_ack_o(data_ack), .rdata_o(rdata), .rvalid_o(rvalid),
    .chip_configuration_register_o(cfg), .common_address_bus_o(caddr),
    .common_data_bus_i(dwire), .common_data_bus_o(dout), .common_data_bus_oe_o(oe),
    .byte_select_output_o(byte_select_output), .bus_read_strobe_n_o(rd_n), .bus_write_strobe_n_o(wr_n),
    .selects_o(sel), .general_pin_eleven_o(gp), .general_pin_eleven_oe_o(gp_oe),
    .phase_two_clock_out_o(ph2), .internal_program_read_qualifier_n_o(qual_n));

  ext_mem_model ext_mem_model_inst (.clk_sys_i(clk), .rst_b_i(rst_b), .addr_i(caddr),
    .dev_data_i(dout), .dev_oe_i(oe), .rd_n_i(rd_n), .wr_n_i(wr_n), .sel_i(sel), .wire_o(dwire));

  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  // bus monitor on the falling edge, as an analyser would capture
  always @(negedge clk) begin
    if (!rd_n || !wr_n) begin
      sel_s = sel;
      byte_select_output_s = byte_select_output;
      gp_s = !(gp_oe && !gp);
    end
    if (!rd_n && !wr_n) both_s = 1;
    if (!wr_n) wr_s = 1;
    if (!qual_n) qual_s = 1;
    if (ph2 !== ph2_p) tog++;
    ph2_p = ph2;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input int lat,
                     output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'hxxxx;
    @(negedge clk);
    dreq = '{1'b1, wr, a, d};
    do begin
      @(posedge clk);
      #1 n++;
      if (rvalid) rd = rdata;
    end while (!data_ack && n < 20);
    chk(16'(n), 16'(lat));
    @(negedge clk);
    dreq = '0;
    @(posedge clk);
    #1 if (rvalid) rd = rdata;
    idle();
  endtask

  task automatic fetch(input logic [15:0] a);
    int n;
    n = 0;
    @(negedge clk);
    prog_addr = a;
    prog_req = 1;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!prog_ack && n < 20);
    chk(16'(n), 16'h3);
    @(negedge clk);
    prog_req = 0;
    idle();
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    int n;
    logic pa, da;
    repeat (20) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    chk(16'(cfg), 16'h00a5);
    $display("straps done");
    banks = 3'h1;
    acc(1, 16'h2005, 16'h1234, 3, r);
    chk(16'(sel_s), 16'h000b);
    chk(16'(byte_select_output_s), 16'h0);
    acc(0, 16'h2005, 16'h0, 3, r);
    chk(r, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        banks = 3'(i + k);
        acc(0, 16'(16'h2000 + i * 16'h2000), 16'h0, 3, r);
        chk(16'(sel_s), k ? 16'h000b : 16'h0007);
      end
    end
    acc(0, 16'ha000, 16'h0, 3, r);
    chk(16'(sel_s), 16'h000f);
    prom = 1;
    acc(0, 16'ha000, 16'h0, 3, r);
    chk(16'(sel_s), 16'h0007);
    prom = 0;
    $display("banks done");
    app_en = 1;
    acc(1, 16'hc010, 16'h0055, 6, r);
    chk(16'(sel_s), 16'h000d);
    chk(16'(gp_s), 16'h0);
    acc(0, 16'hd000, 16'h0, 6, r);
    chk(16'(sel_s), 16'h000e);
    $display("app and disk done");
    wr_s = 0;
    fetch(16'h3000);
    chk(16'(sel_s), 16'h0007);
    chk(16'({wr_s, qual_s}), 16'h0);
    tog = 0;
    repeat (8) @(negedge clk);
    chk(16'(tog), 16'h0);
    trace = 1;
    tog = 0;
    repeat (8) @(negedge clk);
    chk(16'(tog > 6), 16'h1);
    fetch(16'h0100);
    chk(16'(qual_s), 16'h1);
    $display("fetch and trace done");
    byte_m = 1;
    acc(0, 16'h2003, 16'h0, 3, r);
    chk(16'(byte_select_output_s), 16'h1);
    acc(0, 16'h2002, 16'h0, 3, r);
    chk(16'(byte_select_output_s), 16'h0);
    acc(0, 16'h2005, 16'h0, 3, r);
    chk(r, 16'h0034);
    $display("byte mode done");
    n = 0;
    pa = 0;
    da = 0;
    @(negedge clk);
    prog_addr = 16'h0200;
    prog_req = 1;
    dreq = '{1'b1, 1'b0, 16'h2005, 16'h0};
    do begin
      @(posedge clk);
      #1 n++;
      pa |= prog_ack;
      da |= data_ack;
      @(negedge clk);
      if (da) prog_req = 0;
      if (da) dreq = '0;
    end while (!(pa && da) && n < 30);
    chk(16'({pa, da, n <= 12}), 16'h7);
    chk(16'(both_s), 16'h0);
    $display("interleave done");
    // second reset with the test pin following reset: polarity sensed
    idle();
    rst_b = 0;
    test_n = 0;
    repeat (4) @(negedge clk);
    rst_b = 1;
    test_n = 1;
    repeat (2) @(negedge clk);
    chk(16'(cfg), 16'h00a5);
    chk(16'(sel), 16'h000c);
    acc(0, 16'hd000, 16'h0, 6, r);
    chk(16'(sel_s), 16'h000d);
    acc(0, 16'hc000, 16'h0, 6, r);
    chk(16'(sel_s), 16'h000e);
    $display("polarity sense done");
    final_report();
  end
endmodule
